/* File: design/ippc_defines.svh */
// Function
// R01 - Primary priority bits pick low (0) or high (1) for seven core sources.
// R02 - Extended priority bits pick low/high for six sources; reserved bits read zero.
// R03 - Extended enable bits pass (1) or mask (0) the six extended requests.
// R04 - Polarity bit per external input: 0 active-low, 1 active-high; config resets 0x01.
// R05 - A 3-bit select field picks which port zero pin each external input watches.
// R06 - Writing idle select halts the CPU after that instruction; peripherals keep running.
// R07 - While idle, all registers and memory keep their contents.
// R08 - An enabled interrupt ends idle and resumes the CPU at the next instruction.
// R09 - A reset ends idle or stop and restarts fetch at address zero.
// R10 - Software should follow the idle write with an instruction of two or more bytes.
// R11 - Watchdog expiry during idle resets the device and ends idle.
// R12 - Writing stop select halts the internal oscillator, CPU and digital peripherals.
// R13 - In stop, interrupts and timers are inactive; only reset ends stop.
// R14 - Software should disable the missing clock detector before long stop periods.
// R15 - Idle select and stop select always read as zero.
// R16 - Upper six power control bits are plain read/write spare flags, reset zero.
// R17 - Trigger type bit per external input: 1 edge, 0 level sensitive.
// R18 - Edge pending flag clears on vectoring; level flag follows the active input.
// R19 - A level source holds its input until recognised and drops it before handler end.
// R20 - High priority preempts a low priority handler; high priority is never preempted.
// R21 - Idle and stop selects are write pulses, never stored state visible to reads.
`ifndef IPPC_DEFINES_SVH
`define IPPC_DEFINES_SVH

// ==========================================
// register addresses
`define IPPC_ADDR_POWER_CONTROL_REG  8'h87
`define IPPC_ADDR_PRIO      8'hB8
`define IPPC_ADDR_PINCFG    8'hE4
`define IPPC_ADDR_EXTEN     8'hE6
`define IPPC_ADDR_EXTPRIO   8'hF6

// ==========================================
// reset values and masks
`define IPPC_RST_POWER_CONTROL       8'h00
`define IPPC_RST_PRIO       8'h80
`define IPPC_RST_PINCFG     8'h01
`define IPPC_RST_EXTEN      8'h00
`define IPPC_RST_EXTPRIO    8'h00
`define IPPC_PRIO_RD_ONE    8'h80
`define IPPC_EXT_MASK       8'hBD
`define IPPC_POWER_CONTROL_SPARE     8'hFC

// ==========================================
// field positions
`define IPPC_BIT_IDLE       0
`define IPPC_BIT_STOP       1
`define IPPC_CFG_ZERO_POL   3
`define IPPC_CFG_ONE_POL    7
`define IPPC_CFG_ZERO_SEL   0
`define IPPC_CFG_ONE_SEL    4
`define IPPC_SEL_W          3

`endif

/* File: design/ippc_pkg.sv */
package ippc_pkg;
  // register access from the core
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ippc_sfr_req_t;

  // per-input external interrupt controls coming from timer_control
  typedef struct packed {
    logic zeroTriggerType;
    logic oneTriggerType;
    logic zeroVectorAck;
    logic oneVectorAck;
  } ippc_ext_ctl_t;

  // power state of the core
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_IDLE,
    PWR_STOP
  } ippc_pwr_t;
endpackage

/* File: design/ippc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ippc_defines.svh"

module ippc_ctrl #(
  parameter int PORT_W = 8
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire ippc_pkg::ippc_sfr_req_t sfrReq,
  output var  logic [7:0]             sfrRdata,
  input  wire logic                   instrDone,
  input  wire logic [PORT_W-1:0]      portZeroPins,
  input  wire ippc_pkg::ippc_ext_ctl_t extCtl,
  input  wire logic [6:0]             coreIrqEnabled,
  input  wire logic [7:0]             extSrcReq,
  input  wire logic                   inHighHandler,
  input  wire logic                   inLowHandler,
  output logic [7:0]                  primaryPrio,
  output logic [7:0]                  extendedPrio,
  output logic [7:0]                  extendedEnable,
  output logic [7:0]                  extReqMasked,
  output logic                        extZeroPending,
  output logic                        extOnePending,
  output logic                        cpuHalted,
  output logic                        oscStopped,
  output logic                        preemptOk
);
  import ippc_pkg::*;

  // ==========================================
  // elaboration checks
  // the pin select field addresses exactly 2**IPPC_SEL_W pins; any other width would
  // leave codes with no pin, or pins that no code can reach
  if (PORT_W != (1 << `IPPC_SEL_W)) begin : g_bad_width
    $error("port width must match the pin select field");
  end

  // ==========================================
  // registers
  logic [7:0] pconSpare_ff;
  logic [7:0] prio_ff;
  logic [7:0] pinCfg_ff;
  logic [7:0] extEn_ff;
  logic [7:0] extPrio_ff;
  logic       idleReq_ff;
  logic       stopReq_ff;
  ippc_pwr_t  pwr_ff;
  ippc_pwr_t  nxt_pwr;
  logic       zeroLvlPrev_ff;
  logic       oneLvlPrev_ff;
  logic       zeroEdgeFlag_ff;
  logic       oneEdgeFlag_ff;
  logic       zeroLvl;
  logic       oneLvl;
  logic       wakeIrq;

  function automatic logic wrHit(input logic [7:0] a);
    wrHit = sfrReq.wrEn && (sfrReq.addr == a);
  endfunction

  // pick a port zero pin and apply polarity
  function automatic logic pinActive(input logic [`IPPC_SEL_W-1:0] sel, input logic pol);
    pinActive = portZeroPins[sel] ~^ pol;
  endfunction

  // ==========================================
  // configuration registers, one process per register
  // primary priority: top bit is fixed one, so no write can ever clear it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prio_ff <= `IPPC_RST_PRIO;
    end else if (wrHit(`IPPC_ADDR_PRIO)) begin
      prio_ff <= sfrReq.wdata | `IPPC_PRIO_RD_ONE;                    // [R01]
    end
  end

  // extended priority: reserved bits are dropped on write, so they always read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      extPrio_ff <= `IPPC_RST_EXTPRIO;
    end else if (wrHit(`IPPC_ADDR_EXTPRIO)) begin
      extPrio_ff <= sfrReq.wdata & `IPPC_EXT_MASK;                    // [R02]
    end
  end

  // extended enable: same reserved mask; a zero bit masks that source
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      extEn_ff <= `IPPC_RST_EXTEN;
    end else if (wrHit(`IPPC_ADDR_EXTEN)) begin
      extEn_ff <= sfrReq.wdata & `IPPC_EXT_MASK;                      // [R03]
    end
  end

  // external input configuration: polarity and pin select, every bit writable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinCfg_ff <= `IPPC_RST_PINCFG;                                  // [R04]
    end else if (wrHit(`IPPC_ADDR_PINCFG)) begin
      pinCfg_ff <= sfrReq.wdata;                                      // [R04] [R05]
    end
  end

  // spare flags: stored for software only; the idle and stop bits never land here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pconSpare_ff <= `IPPC_RST_POWER_CONTROL;                                 // [R16]
    end else if (wrHit(`IPPC_ADDR_POWER_CONTROL_REG)) begin
      pconSpare_ff <= sfrReq.wdata & `IPPC_POWER_CONTROL_SPARE;                // [R16]
    end
  end

  // ==========================================
  // idle/stop selects are one-shot requests, never readable
  // a request lives only until the writing instruction ends, so it cannot fire twice
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idleReq_ff <= 1'b0;
    end else begin
      if (wrHit(`IPPC_ADDR_POWER_CONTROL_REG) && sfrReq.wdata[`IPPC_BIT_IDLE]) idleReq_ff <= 1'b1;              // [R21]
      else if (instrDone) idleReq_ff <= 1'b0;
    end
  end

  // stop request, same life span as the idle request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stopReq_ff <= 1'b0;
    end else begin
      if (wrHit(`IPPC_ADDR_POWER_CONTROL_REG) && sfrReq.wdata[`IPPC_BIT_STOP]) stopReq_ff <= 1'b1;              // [R21]
      else if (instrDone) stopReq_ff <= 1'b0;
    end
  end

  // ==========================================
  // external inputs: pin select, polarity, trigger type
  assign zeroLvl = pinActive(pinCfg_ff[`IPPC_CFG_ZERO_SEL +: `IPPC_SEL_W], pinCfg_ff[`IPPC_CFG_ZERO_POL]); // [R04] [R05]
  assign oneLvl  = pinActive(pinCfg_ff[`IPPC_CFG_ONE_SEL +: `IPPC_SEL_W], pinCfg_ff[`IPPC_CFG_ONE_POL]);   // [R04] [R05]

  // edge flags: set wins over the vector-time clear; frozen in stop
  // previous levels reset to active, so an input already active at reset gives no false edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      zeroLvlPrev_ff  <= 1'b1;
      oneLvlPrev_ff   <= 1'b1;
      zeroEdgeFlag_ff <= 1'b0;
      oneEdgeFlag_ff  <= 1'b0;
    end else if (pwr_ff != PWR_STOP) begin                                                           // [R13]
      zeroLvlPrev_ff <= zeroLvl;
      oneLvlPrev_ff  <= oneLvl;
      if (zeroLvl && !zeroLvlPrev_ff) zeroEdgeFlag_ff <= 1'b1;                                        // [R17]
      else if (extCtl.zeroVectorAck) zeroEdgeFlag_ff <= 1'b0;                                         // [R18]
      if (oneLvl && !oneLvlPrev_ff) oneEdgeFlag_ff <= 1'b1;                                           // [R17]
      else if (extCtl.oneVectorAck) oneEdgeFlag_ff <= 1'b0;                                           // [R18]
    end
  end

  // ==========================================
  // registered request outputs, gated off during stop
  // stop gates the outputs as well as the flags, so a live level cannot leak to the core
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      extZeroPending <= 1'b0;
    end else begin
      extZeroPending <= (pwr_ff != PWR_STOP) &&
                        (extCtl.zeroTriggerType ? zeroEdgeFlag_ff : zeroLvl);                         // [R17] [R18] [R13]
    end
  end

  // input one: same choice between edge flag and live level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      extOnePending <= 1'b0;
    end else begin
      extOnePending <= (pwr_ff != PWR_STOP) &&
                       (extCtl.oneTriggerType ? oneEdgeFlag_ff : oneLvl);                             // [R17] [R18] [R13]
    end
  end

  // extended requests pass only where their enable bit is set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      extReqMasked <= 8'h00;
    end else begin
      extReqMasked <= (pwr_ff == PWR_STOP) ? 8'h00 : (extSrcReq & extEn_ff);                          // [R03] [R13]
    end
  end

  // ==========================================
  // power state: idle ends on an enabled interrupt, stop only on reset
  assign wakeIrq = (|coreIrqEnabled) || (|(extSrcReq & extEn_ff));

  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      PWR_RUN: begin
        if (stopReq_ff && instrDone) nxt_pwr = PWR_STOP;                                              // [R12]
        else if (idleReq_ff && instrDone) nxt_pwr = PWR_IDLE;                                         // [R06]
      end
      PWR_IDLE: begin
        if (wakeIrq) nxt_pwr = PWR_RUN;                                                               // [R08]
      end
      PWR_STOP: begin
        nxt_pwr = PWR_STOP;                                                                           // [R13]
      end
      default: begin
        nxt_pwr = PWR_RUN;  // the unused code falls back to run rather than locking up
      end
    endcase
  end

  // any reset (watchdog, detector, pin) arrives on sys_rst and restarts the core
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_ff     <= PWR_RUN;                                                                          // [R09] [R11]
      cpuHalted  <= 1'b0;
      oscStopped <= 1'b0;
    end else begin
      pwr_ff     <= nxt_pwr;                                                                          // [R07]
      cpuHalted  <= nxt_pwr != PWR_RUN;                                                               // [R06] [R12]
      oscStopped <= nxt_pwr == PWR_STOP;                                                              // [R12]
    end
  end

  // ==========================================
  // priority outputs, one cycle behind the registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      primaryPrio    <= `IPPC_RST_PRIO;
      extendedPrio   <= `IPPC_RST_EXTPRIO;
      extendedEnable <= `IPPC_RST_EXTEN;
    end else begin
      primaryPrio    <= prio_ff;                                                                      // [R01]
      extendedPrio   <= extPrio_ff;                                                                   // [R02]
      extendedEnable <= extEn_ff;                                                                     // [R03]
    end
  end

  // preemption permission for a high priority request
  // a high handler blocks everything; a low handler, or none, lets a high request in
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preemptOk <= 1'b1;
    end else begin
      preemptOk <= !inHighHandler;                                                                    // [R20]
    end
  end

  // ==========================================
  // read data, registered one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfrRdata <= 8'h00;
    end else if (sfrReq.rdEn) begin
      unique case (sfrReq.addr)
        `IPPC_ADDR_POWER_CONTROL_REG: sfrRdata <= pconSpare_ff;                                                // [R15]
        `IPPC_ADDR_PRIO:     sfrRdata <= prio_ff;
        `IPPC_ADDR_PINCFG:   sfrRdata <= pinCfg_ff;
        `IPPC_ADDR_EXTEN:    sfrRdata <= extEn_ff;
        `IPPC_ADDR_EXTPRIO:  sfrRdata <= extPrio_ff;                                                  // [R02]
        default:             sfrRdata <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // checks
  // all checks sample on the rising edge; the assertions are silent while reset is held, the covers are not
  a_idle_reads_zero: assert property (@(posedge clk) disable iff (sys_rst)   // [R15]
    sfrReq.rdEn && sfrReq.addr == `IPPC_ADDR_POWER_CONTROL_REG |=> sfrRdata[1:0] == 2'b00)
    else $error("idle or stop select read back nonzero");
  a_stop_sticks: assert property (@(posedge clk) disable iff (sys_rst)       // [R13]
    pwr_ff == PWR_STOP |=> pwr_ff == PWR_STOP && oscStopped)
    else $error("stop mode left without reset");
  a_idle_entry: assert property (@(posedge clk) disable iff (sys_rst)        // [R06]
    pwr_ff == PWR_RUN && idleReq_ff && !stopReq_ff && instrDone |=> cpuHalted && pwr_ff == PWR_IDLE)
    else $error("idle not entered after instruction end");
  a_idle_wake: assert property (@(posedge clk) disable iff (sys_rst)         // [R08]
    pwr_ff == PWR_IDLE && wakeIrq |=> !cpuHalted)
    else $error("enabled interrupt did not end idle");
  a_prio_top_one: assert property (@(posedge clk) disable iff (sys_rst)      // [R01]
    wrHit(`IPPC_ADDR_PRIO) |=> prio_ff == (($past(sfrReq.wdata)) | `IPPC_PRIO_RD_ONE))
    else $error("primary priority write wrong");
  a_ext_reserved: assert property (@(posedge clk) disable iff (sys_rst)      // [R02]
    (extPrio_ff & ~`IPPC_EXT_MASK) == 8'h00 && (extEn_ff & ~`IPPC_EXT_MASK) == 8'h00)
    else $error("reserved extended bit set");
  a_mask_gate: assert property (@(posedge clk) disable iff (sys_rst)         // [R03]
    pwr_ff != PWR_STOP ##1 1'b1 |-> extReqMasked == ($past(extSrcReq) & $past(extEn_ff)))
    else $error("extended request mask wrong");
  a_edge_clear: assert property (@(posedge clk) disable iff (sys_rst)        // [R18]
    pwr_ff != PWR_STOP && extCtl.zeroVectorAck && !(zeroLvl && !zeroLvlPrev_ff) |=> !zeroEdgeFlag_ff)
    else $error("edge flag not cleared on vector");
  a_high_no_preempt: assert property (@(posedge clk) disable iff (sys_rst)   // [R20]
    inHighHandler |=> !preemptOk)
    else $error("high priority handler preemptable");

  // stop is entered at the end of the writing instruction
  a_stop_entry: assert property (@(posedge clk) disable iff (sys_rst)        // [R12]
    pwr_ff == PWR_RUN && stopReq_ff && instrDone |=> pwr_ff == PWR_STOP && oscStopped && cpuHalted)
    else $error("stop not entered after instruction end");
  // idle keeps its state until an enabled request arrives
  a_idle_hold: assert property (@(posedge clk) disable iff (sys_rst)         // [R07]
    pwr_ff == PWR_IDLE && !wakeIrq |=> pwr_ff == PWR_IDLE && cpuHalted && !oscStopped)
    else $error("idle left without an enabled interrupt");
  // a request ends with its instruction and is never kept
  a_req_one_shot: assert property (@(posedge clk) disable iff (sys_rst)      // [R21]
    idleReq_ff && instrDone && !(wrHit(`IPPC_ADDR_POWER_CONTROL_REG) && sfrReq.wdata[`IPPC_BIT_IDLE]) |=> !idleReq_ff)
    else $error("idle request outlived its instruction");
  // stop silences every request output
  a_stop_quiet: assert property (@(posedge clk) disable iff (sys_rst)        // [R13]
    pwr_ff == PWR_STOP |=> !extZeroPending && !extOnePending && extReqMasked == 8'h00)
    else $error("request passed during stop");
  // pin configuration takes the written byte whole
  a_cfg_write: assert property (@(posedge clk) disable iff (sys_rst)         // [R05]
    wrHit(`IPPC_ADDR_PINCFG) |=> pinCfg_ff == $past(sfrReq.wdata))
    else $error("pin configuration write wrong");
  // spare flags take the upper six bits only
  a_spare_write: assert property (@(posedge clk) disable iff (sys_rst)       // [R16]
    wrHit(`IPPC_ADDR_POWER_CONTROL_REG) |=> pconSpare_ff == ($past(sfrReq.wdata) & `IPPC_POWER_CONTROL_SPARE))
    else $error("spare flag write wrong");
  // an active edge on input zero sets its flag
  a_edge_set: assert property (@(posedge clk) disable iff (sys_rst)          // [R17]
    pwr_ff != PWR_STOP && zeroLvl && !zeroLvlPrev_ff |=> zeroEdgeFlag_ff)
    else $error("edge flag not set");
  // a level input is passed on as it stands
  a_level_follow: assert property (@(posedge clk) disable iff (sys_rst)      // [R18]
    pwr_ff != PWR_STOP && !extCtl.zeroTriggerType |=> extZeroPending == $past(zeroLvl))
    else $error("level pending does not follow input");
  // a low handler may be preempted by a high request
  a_low_preempt: assert property (@(posedge clk) disable iff (sys_rst)       // [R20]
    inLowHandler && !inHighHandler |=> preemptOk)
    else $error("low priority handler not preemptable");

  c_idle_wake: cover property (@(posedge clk) pwr_ff == PWR_IDLE ##1 pwr_ff == PWR_RUN);
  c_stop_enter: cover property (@(posedge clk) pwr_ff == PWR_RUN ##1 pwr_ff == PWR_STOP);
  c_edge_irq: cover property (@(posedge clk) zeroEdgeFlag_ff ##1 extCtl.zeroVectorAck);
  c_level_irq: cover property (@(posedge clk) !extCtl.zeroTriggerType && extZeroPending);
  c_low_preempt: cover property (@(posedge clk) inLowHandler ##1 preemptOk);
endmodule
`default_nettype wire

/* File: dv/ippc_src_model.sv */
`timescale 1ns/1ps
`default_nettype none

module ippc_src_model (
  input  wire logic       clk,
  input  wire logic [7:0] pinCmd,
  input  wire logic [7:0] reqCmd,
  output var  logic [7:0] portZeroPins,
  output var  logic [7:0] extSrcReq
);
  // ==========================================
  // far side sources
  // a level source holds its pin until the bench releases it, so it stays active until recognised
  always_ff @(posedge clk) begin
    portZeroPins <= pinCmd; // pins change only on the clock, as the block expects synchronous levels
    extSrcReq    <= reqCmd;
  end
endmodule

`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ippc_pkg::*;
  logic                clk;
  logic                sysRst;
  ippc_sfr_req_t       sfrReq;
  ippc_ext_ctl_t       extCtl;
  logic [7:0]          sfrRdata, pinCmd, reqCmd, portZeroPins, extSrcReq, primaryPrio, extendedPrio;
  logic [7:0]          extendedEnable, extReqMasked, rd;
  logic [6:0]          coreIrqEnabled;
  logic                instrDone, inHighHandler, extZeroPending, extOnePending, cpuHalted, oscStopped, preemptOk;
  logic                inLowHandler;
  int                  numErrors, checkCount;
  logic [7:0]          rstTab [5][2] = '{'{8'h87, 8'h00}, '{8'hB8, 8'h80}, '{8'hE4, 8'h01}, '{8'hE6, 8'h00},
                                        '{8'hF6, 8'h00}};

  // ==========================================
  // clock, design and far side
  always #5 clk = ~clk;
  ippc_src_model src_u (.clk(clk), .pinCmd(pinCmd), .reqCmd(reqCmd), .portZeroPins(portZeroPins),
                        .extSrcReq(extSrcReq));
  ippc_ctrl dut_u (.clk(clk), .sys_rst(sysRst), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .instrDone(instrDone),
                   .portZeroPins(portZeroPins), .extCtl(extCtl), .coreIrqEnabled(coreIrqEnabled),
                   .extSrcReq(extSrcReq), .inHighHandler(inHighHandler), .inLowHandler(inLowHandler),
                   .primaryPrio(primaryPrio), .extendedPrio(extendedPrio), .extendedEnable(extendedEnable),
                   .extReqMasked(extReqMasked), .extZeroPending(extZeroPending), .extOnePending(extOnePending),
                   .cpuHalted(cpuHalted), .oscStopped(oscStopped), .preemptOk(preemptOk));

  // ==========================================
  // access tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      numErrors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one cycle strobe; the next call waits an edge first, so a signal is never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    sfrReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
    cyc(1);
    sfrReq.wrEn = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    sfrReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    sfrReq.rdEn = 1'b0;
    cyc(1);
    chk("read data", exp, sfrRdata);
  endtask
  task automatic waitHalt(input logic exp);
    int i;
    for (i = 0; i < 20 && cpuHalted !== exp; i++) cyc(1);
    chk("halted", {7'h00, exp}, {7'h00, cpuHalted});
    if (cpuHalted !== exp) reportAndStop();
  endtask
  task automatic reportAndStop();
    if (numErrors == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    clk = 0; sysRst = 1; sfrReq = '0; extCtl = '0; pinCmd = 8'h00; reqCmd = 8'h00;
    coreIrqEnabled = 7'h00; instrDone = 0; inHighHandler = 0; numErrors = 0; checkCount = 0;
    inLowHandler = 0;
    cyc(20);
    sysRst = 0;
    for (int i = 0; i < 5; i++) rdchk(rstTab[i][0], rstTab[i][1]);
    rdchk(8'h90, 8'h00); // unmapped place reads zero
    wr(8'hB8, 8'h7F);
    rdchk(8'hB8, 8'hFF);
    chk("prio out", 8'hFF, primaryPrio);
    wr(8'hF6, 8'hFF);
    rdchk(8'hF6, 8'hBD);
    wr(8'hE6, 8'hFF);
    rdchk(8'hE6, 8'hBD);
    chk("enable out", 8'hBD, extendedEnable);
    reqCmd = 8'hFF;
    cyc(4);
    chk("masked", 8'hBD, extReqMasked);
    chk("ext prio out", 8'hBD, extendedPrio);
    wr(8'hE6, 8'h00);
    cyc(4);
    chk("masked off", 8'h00, extReqMasked);
    reqCmd = 8'h00;
    // every pin code on the zero input, level sensitive and active high
    for (int s = 0; s < 8; s++) begin
      wr(8'hE4, 8'h08 | 8'(s));
      pinCmd = 8'h01 << s;
      cyc(4);
      chk("level pend", 8'h01, {7'h00, extZeroPending});
      pinCmd = ~(8'h01 << s);
      cyc(4);
      chk("level idle", 8'h00, {7'h00, extZeroPending});
    end
    // edge on pin five for zero, active low level on pin two for one
    wr(8'hE4, 8'h2D);
    extCtl.zeroTriggerType = 1;
    pinCmd = 8'h00;
    cyc(2);
    // vectoring clears the flag left by the level loop and the select change
    extCtl.zeroVectorAck = 1;
    cyc(1);
    extCtl.zeroVectorAck = 0;
    cyc(4);
    chk("edge quiet", 8'h00, {7'h00, extZeroPending});
    pinCmd = 8'h20;
    cyc(4);
    chk("edge pend", 8'h01, {7'h00, extZeroPending});
    chk("low pend", 8'h01, {7'h00, extOnePending});
    extCtl.zeroVectorAck = 1;
    cyc(1);
    extCtl.zeroVectorAck = 0;
    pinCmd = 8'hFF;
    cyc(4);
    chk("edge clear", 8'h00, {7'h00, extZeroPending});
    chk("low idle", 8'h00, {7'h00, extOnePending});
    inHighHandler = 1;
    cyc(3);
    chk("preempt", 8'h00, {7'h00, preemptOk});
    inHighHandler = 0;
    cyc(3);
    chk("preempt ok", 8'h01, {7'h00, preemptOk});
    inLowHandler = 1;
    cyc(3);
    chk("low preempt", 8'h01, {7'h00, preemptOk});
    inLowHandler = 0;
    // idle entry and wake by an enabled extended request
    wr(8'hE6, 8'h04);
    wr(8'h87, 8'hFD); // the reads below stand for the multi-byte follow-up
    instrDone = 1;
    cyc(1);
    instrDone = 0;
    waitHalt(1);
    chk("osc idle", 8'h00, {7'h00, oscStopped});
    rdchk(8'h87, 8'hFC);
    rdchk(8'hE4, 8'h2D);
    reqCmd = 8'h04;
    waitHalt(0);
    reqCmd = 8'h00;
    // idle again, woken this time by an enabled core source
    wr(8'h87, 8'h01);
    instrDone = 1;
    cyc(1);
    instrDone = 0;
    waitHalt(1);
    coreIrqEnabled = 7'h01;
    waitHalt(0);
    coreIrqEnabled = 7'h00;
    // stop entry, nothing but reset ends it
    wr(8'h87, 8'h02);
    instrDone = 1;
    cyc(1);
    instrDone = 0;
    waitHalt(1);
    chk("osc stop", 8'h01, {7'h00, oscStopped});
    reqCmd = 8'hFF;
    coreIrqEnabled = 7'h7F;
    cyc(6);
    chk("stop holds", 8'h01, {7'h00, cpuHalted});
    chk("stop masked", 8'h00, extReqMasked);
    sysRst = 1; // a detector or watchdog expiry arrives as this reset
    cyc(2);
    sysRst = 0;
    reqCmd = 8'h00;
    coreIrqEnabled = 7'h00;
    cyc(1);
    chk("reset wake", 8'h00, {7'h00, cpuHalted});
    rdchk(8'hE6, 8'h00);
    reportAndStop();
  end
endmodule

`default_nettype wire
